// ==== include/gpo_override_cfg.svh ====
/*
  Addresses, field positions, codes and reset values for the output pin
  override block.
  Assumes a 32-bit AXI4-Lite bus with 16-bit byte addresses, one word per register.
*/
`ifndef GPO_OVERRIDE_CFG_SVH
`define GPO_OVERRIDE_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------------
`define PIN_OVERRIDE_ENABLE_IDX 14'h0724
`define POS_PIN_STATUS_POINTER_IDX 14'h0725
`define POS_PIN_OVERRIDE_MODE_IDX 14'h0727

// ----------------------------------------------------------------------------
// Reset values and writable bit masks
// ----------------------------------------------------------------------------
`define PIN_OVERRIDE_ENABLE_RST 8'h00
`define POS_PIN_STATUS_POINTER_RST 16'h0000
`define POS_PIN_OVERRIDE_MODE_RST 8'h01
`define PIN_OVERRIDE_ENABLE_MASK 8'h03
`define POS_PIN_STATUS_POINTER_MASK 16'h7f7f
`define POS_PIN_OVERRIDE_MODE_MASK 8'h07

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ENABLE_POS_BIT 0
`define ENABLE_NEG_BIT 1
`define POINTER_BIT_HI 14
`define POINTER_BIT_LO 12
`define POINTER_PAGE_HI 11
`define POINTER_PAGE_LO 8
`define POINTER_OFFSET_HI 6
`define POINTER_OFFSET_LO 0
`define MODE_HI 2
`define MODE_LO 0

// ----------------------------------------------------------------------------
// Mode codes and bus answers
// ----------------------------------------------------------------------------
`define MODE_OUTPUT 3'h1
`define MODE_STATUS 3'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== include/gpo_override_pkg.sv ====
/*
  Types shared by the output pin override block.
  Assumes the constants of gpo_override_cfg.svh are used alongside.
*/
package gpo_override_pkg;

  typedef logic [2:0] mode_type;
  typedef logic [15:0] pointer_type;
  typedef logic [10:0] map_addr_type;

endpackage

// ==== rtl/output_pin_gpo_override.sv ====
/*
  Output pin override for one clock output pair, with its AXI4-Lite registers.
  Assumes the negative-pin mode and pointer, the output value bits and the
  divided clocks come from neighbouring logic, and that the host register map
  returns the addressed byte combinationally.
*/
// Function
// - The positive pin follows the divided clock while enable bit 0 is clear, else its override mode.
// - The negative pin follows the divided clock while enable bit 1 is clear, else its override mode.
// - Pointer bits 14 to 12 pick the bit inside the selected host map byte.
// - Pointer bits 11 to 8 pick the host map page holding the mirrored bit.
// - Pointer bits 6 to 0 pick the byte offset in the page, and bits 15 and 7 are reserved.
// - Mode 001 drives the pin with the software output value bit, other codes than 001 and 011 are reserved.
// - Mode 011 continuously copies the selected host map bit onto the pin.
`include "gpo_override_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module output_pin_gpo_override
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic div_clk_pos,
  input wire logic div_clk_neg,
  input wire logic general_purpose_pin_value_pos,
  input wire logic general_purpose_pin_value_neg,
  input wire logic [2:0] neg_pin_override_mode,
  input wire logic [15:0] neg_pin_status_pointer,
  output logic [10:0] map_addr_pos,
  output logic [10:0] map_addr_neg,
  input wire logic [7:0] map_byte_pos,
  input wire logic [7:0] map_byte_neg,
  output logic pin_pos,
  output logic pin_neg
);

  // --------------------------------------------------------------------------
  // Bus slave state
  // --------------------------------------------------------------------------
  logic aw_have_q;
  logic aw_have_d;
  logic [13:0] aw_idx_q;
  logic [13:0] aw_idx_d;
  logic w_have_q;
  logic w_have_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic [3:0] w_strb_q;
  logic [3:0] w_strb_d;
  logic awready_q;
  logic awready_d;
  logic wready_q;
  logic wready_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic do_write;

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic [7:0] enable_q;
  logic [7:0] enable_d;
  gpo_override_pkg::pointer_type pointer_q;
  gpo_override_pkg::pointer_type pointer_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;

  always_comb
  begin
    aw_have_d = aw_have_q;
    aw_idx_d = aw_idx_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    enable_d = enable_q;
    pointer_d = pointer_q;
    mode_d = mode_q;
    do_write = aw_have_q && w_have_q && !bvalid_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      aw_idx_d = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (do_write)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `RESP_OKAY;
      unique case (aw_idx_q)
        `PIN_OVERRIDE_ENABLE_IDX:
        begin
          if (w_strb_q[0])
          begin
            enable_d = w_data_q[7:0] & `PIN_OVERRIDE_ENABLE_MASK;
          end
        end
        `POS_PIN_STATUS_POINTER_IDX:
        begin
          if (w_strb_q[0])
          begin
            pointer_d[7:0] = w_data_q[7:0] & 8'h7f;
          end
          if (w_strb_q[1])
          begin
            pointer_d[15:8] = w_data_q[15:8] & 8'h7f;
          end
        end
        `POS_PIN_OVERRIDE_MODE_IDX:
        begin
          if (w_strb_q[0])
          begin
            mode_d = w_data_q[7:0] & `POS_PIN_OVERRIDE_MODE_MASK;
          end
        end
        default:
        begin
          bresp_d = `RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      unique case (s_axi_araddr[15:2])
        `PIN_OVERRIDE_ENABLE_IDX:
        begin
          rdata_d = {24'h000000, enable_q & `PIN_OVERRIDE_ENABLE_MASK};
        end
        `POS_PIN_STATUS_POINTER_IDX:
        begin
          rdata_d = {16'h0000, pointer_q & `POS_PIN_STATUS_POINTER_MASK};
        end
        `POS_PIN_OVERRIDE_MODE_IDX:
        begin
          rdata_d = {24'h000000, mode_q & `POS_PIN_OVERRIDE_MODE_MASK};
        end
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
    // One read at a time keeps the answer path to a single register.
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      aw_idx_q <= 14'h0000;
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
      enable_q <= `PIN_OVERRIDE_ENABLE_RST;
      pointer_q <= `POS_PIN_STATUS_POINTER_RST;
      mode_q <= `POS_PIN_OVERRIDE_MODE_RST;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      aw_idx_q <= aw_idx_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      enable_q <= enable_d;
      pointer_q <= pointer_d;
      mode_q <= mode_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // --------------------------------------------------------------------------
  // Pin drivers, index 0 is the positive pin and index 1 the negative pin
  // --------------------------------------------------------------------------
  logic [1:0] pin_en;
  logic [1:0] div_clk;
  logic [1:0] gpo_value;
  gpo_override_pkg::mode_type pin_mode [2];
  gpo_override_pkg::pointer_type pin_pointer [2];
  logic [7:0] map_byte [2];
  gpo_override_pkg::map_addr_type map_addr_q [2];
  gpo_override_pkg::map_addr_type map_addr_d [2];
  logic [1:0] pin_q;
  logic [1:0] pin_d;

  assign pin_en = enable_q[1:0];
  assign div_clk = {div_clk_neg, div_clk_pos};
  assign gpo_value = {general_purpose_pin_value_neg, general_purpose_pin_value_pos};
  assign pin_mode[0] = mode_q[`MODE_HI:`MODE_LO];
  assign pin_mode[1] = neg_pin_override_mode;
  assign pin_pointer[0] = pointer_q;
  assign pin_pointer[1] = neg_pin_status_pointer;
  assign map_byte[0] = map_byte_pos;
  assign map_byte[1] = map_byte_neg;

  for (genvar i = 0; i < 2; i++)
  begin : g_pin
    always_comb
    begin
      map_addr_d[i][10:7] = pin_pointer[i][`POINTER_PAGE_HI:`POINTER_PAGE_LO];
      map_addr_d[i][6:0] = pin_pointer[i][`POINTER_OFFSET_HI:`POINTER_OFFSET_LO];
      if (!pin_en[i])
      begin
        pin_d[i] = div_clk[i];
      end
      else if (pin_mode[i] == `MODE_OUTPUT)
      begin
        pin_d[i] = gpo_value[i];
      end
      else if (pin_mode[i] == `MODE_STATUS)
      begin
        pin_d[i] = map_byte[i][pin_pointer[i][`POINTER_BIT_HI:`POINTER_BIT_LO]];
      end
      // Reserved codes park the pin low rather than leave it undefined.
      else
      begin
        pin_d[i] = 1'b0;
      end
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        map_addr_q[i] <= 11'h000;
        pin_q[i] <= 1'b0;
      end
      else
      begin
        map_addr_q[i] <= map_addr_d[i];
        pin_q[i] <= pin_d[i];
      end
    end
  end

  // The registered pin adds one cycle to the divided clock; it is the price of a flop-driven output.
  assign map_addr_pos = map_addr_q[0];
  assign map_addr_neg = map_addr_q[1];
  assign pin_pos = pin_q[0];
  assign pin_neg = pin_q[1];

endmodule // output_pin_gpo_override

`default_nettype wire

// ==== verification/output_pin_gpo_override_properties.sv ====
/*
  Checker for the output pin override block.
  Assumes it is bound to the block's top module and sees only its ports.
*/
`include "gpo_override_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module output_pin_gpo_override_properties
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic div_clk_pos,
  input wire logic div_clk_neg,
  input wire logic general_purpose_pin_value_neg,
  input wire logic [2:0] neg_pin_override_mode,
  input wire logic [15:0] neg_pin_status_pointer,
  input wire logic [10:0] map_addr_neg,
  input wire logic [7:0] map_byte_neg,
  input wire logic pin_pos,
  input wire logic pin_neg
);
  logic [15:0] a_q;
  logic [1:0] d_q;
  logic s_q;
  logic bv_q;
  logic [1:0] en_q;
  wire logic sel_neg = map_byte_neg[neg_pin_status_pointer[14:12]];
  wire logic [10:0] addr_neg = {neg_pin_status_pointer[11:8], neg_pin_status_pointer[6:0]};

  // The enable register is rebuilt from bus writes, since the checker sees only ports.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_q <= 2'h0;
      bv_q <= 1'b0;
    end
    else
    begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
        a_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        d_q <= s_axi_wdata[1:0];
        s_q <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && !bv_q && s_q && a_q[15:2] == `PIN_OVERRIDE_ENABLE_IDX)
        en_q <= d_q;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pos_clock;
    !en_q[0] && $past(aresetn) |-> pin_pos == $past(div_clk_pos);
  endproperty
  a_pos_clock: assert property (p_pos_clock) else $error("pin_pos does not follow its divided clock");

  property p_neg_clock;
    !en_q[1] && $past(aresetn) |-> pin_neg == $past(div_clk_neg);
  endproperty
  a_neg_clock: assert property (p_neg_clock) else $error("pin_neg does not follow its divided clock");

  property p_neg_output;
    en_q[1] && $past(aresetn) && $past(neg_pin_override_mode) == `MODE_OUTPUT
      |-> pin_neg == $past(general_purpose_pin_value_neg);
  endproperty
  a_neg_output: assert property (p_neg_output) else $error("pin_neg misses its output value");

  property p_neg_status;
    en_q[1] && $past(aresetn) && $past(neg_pin_override_mode) == `MODE_STATUS |-> pin_neg == $past(sel_neg);
  endproperty
  a_neg_status: assert property (p_neg_status) else $error("pin_neg misses the mirrored bit");

  property p_neg_reserved;
    en_q[1] && $past(aresetn) && !($past(neg_pin_override_mode) inside {`MODE_OUTPUT, `MODE_STATUS}) |-> !pin_neg;
  endproperty
  a_neg_reserved: assert property (p_neg_reserved) else $error("pin_neg driven in a reserved mode");

  property p_neg_addr;
    $past(aresetn) |-> map_addr_neg == $past(addr_neg);
  endproperty
  a_neg_addr: assert property (p_neg_addr) else $error("map_addr_neg misses page or offset");

  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("read data has upper bits set");

  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read answer dropped early");
endmodule // output_pin_gpo_override_properties

`default_nettype wire

// ==== verification/output_pin_gpo_override_tb.sv ====
/*
  Testbench for the output pin override block, acting as bus master and host map.
  Assumes the design and checker files are compiled before it.
*/
`include "gpo_override_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end

module output_pin_gpo_override_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000, neg_pin_status_pointer = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic div_clk_pos = 1'b0, div_clk_neg = 1'b0, general_purpose_pin_value_pos = 1'b0, general_purpose_pin_value_neg = 1'b0;
  logic [2:0] neg_pin_override_mode = 3'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_pos, pin_neg;
  logic [10:0] map_addr_pos, map_addr_neg;
  logic [7:0] map_byte_pos, map_byte_neg;
  int err_total = 0;
  int comparisons = 0;

  function automatic logic [7:0] host_byte(input logic [10:0] a);
    return a[7:0] ^ {a[10:8], 5'h00};
  endfunction
  assign map_byte_pos = host_byte(map_addr_pos);
  assign map_byte_neg = host_byte(map_addr_neg);

  initial forever #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    div_clk_pos <= ~div_clk_pos;
    div_clk_neg <= div_clk_pos;
  end

  output_pin_gpo_override u_dut (.*);

  task final_report;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50)
    begin
      err_total++;
      final_report;
    end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
      if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
    end
    if (n == 50)
    begin
      err_total++;
      final_report;
    end
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
  endtask

  initial
  begin
    logic [15:0] p;
    logic [7:0] hb;
    int i;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(16'h1c90, 32'h0, `RESP_OKAY);
    rd(16'h1c94, 32'h0, `RESP_OKAY);
    rd(16'h1c9c, 32'h1, `RESP_OKAY);
    rd(16'h0008, 32'h0, `RESP_SLVERR);
    wr(16'h0008, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
    repeat (4) @(posedge aclk);
    `CHK(pin_pos, ~div_clk_pos)
    wr(16'h1c90, 32'hffff_ffff, 4'hf, `RESP_OKAY);
    rd(16'h1c90, 32'h3, `RESP_OKAY);
    wr(16'h1c94, 32'h0000_ffff, 4'hf, `RESP_OKAY);
    rd(16'h1c94, 32'h7f7f, `RESP_OKAY);
    wr(16'h1c94, 32'h0000_1234, 4'h1, `RESP_OKAY);
    rd(16'h1c94, 32'h7f34, `RESP_OKAY);
    general_purpose_pin_value_pos <= 1'b1;
    general_purpose_pin_value_neg <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      wr(16'h1c9c, 32'hffff_fff8 | 32'(i), 4'hf, `RESP_OKAY);
      rd(16'h1c9c, 32'(i), `RESP_OKAY);
      `CHK(pin_pos, 1'(i == 1))
    end
    wr(16'h1c9c, 32'h0000_0003, 4'h1, `RESP_OKAY);
    for (i = 0; i < 8; i++)
    begin
      p = {1'b0, 3'(i), 4'(i + 5), 1'b0, 7'(i * 19)};
      hb = host_byte({p[11:8], p[6:0]});
      wr(16'h1c94, 32'(p), 4'h3, `RESP_OKAY);
      repeat (4) @(posedge aclk);
      `CHK(map_addr_pos, {p[11:8], p[6:0]})
      `CHK(pin_pos, hb[p[14:12]])
      neg_pin_override_mode <= 3'(i);
      neg_pin_status_pointer <= p;
      repeat (4) @(posedge aclk);
      `CHK(pin_neg, (i == 1) ? 1'b1 : (i == 3) ? hb[p[14:12]] : 1'b0)
    end
    wr(16'h1c90, 32'h0, 4'hf, `RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK(pin_pos, ~div_clk_pos)
    `CHK(pin_neg, ~div_clk_neg)
    final_report;
  end
endmodule // output_pin_gpo_override_tb

bind output_pin_gpo_override output_pin_gpo_override_properties u_props (.*);

`default_nettype wire
